// >>> core/icm_consts.svh
// Constants for the interrupt collect and mask block
`ifndef ICM_CONSTS_SVH
`define ICM_CONSTS_SVH
`define ICM_BUS_W        64
`define ICM_LATCH_W      7
`define ICM_SEL_MSB      6
`define ICM_SEL_LSB      4
`define ICM_SEL_HIT      3'h0
`define ICM_WE_MSB       22
`define ICM_WE_LSB       16
`define ICM_VAL_MSB      6
`define ICM_VAL_LSB      0
`define ICM_NMI_BIT      6
`define ICM_TMR_BIT      5
`define ICM_HW_MSB       4
`define ICM_HW_PINS      6
`define ICM_PEND_W       8
`define ICM_PEND_TOP     7
`define ICM_PEND_HW_MSB  6
`define ICM_PEND_HW_LSB  2
`define ICM_PEND_SW_MSB  1
`define ICM_LATCH_RESET  7'h00
`endif

// >>> core/icm_pkg.sv
// Types for the interrupt collect and mask block
`include "icm_consts.svh"
package icm_pkg;
    typedef struct packed {
        logic [`ICM_HW_PINS-1:0] intSync1;
        logic [`ICM_HW_PINS-1:0] intSync2;
        logic                    nmiSync1;
        logic                    nmiSync2;
        logic                    addrHit;
        logic [`ICM_LATCH_W-1:0] latchBits;
        logic                    nmiPrev;
        logic                    nmiException;
        logic [`ICM_PEND_W-1:0]  pendingBits;
        logic                    interruptRequest;
    } icm_state_t;
endpackage

// >>> core/interrupt_collect_mask.sv
// Interrupt gathering, masking and nonmaskable edge detection
// How it works
// - Six hardware, timer, two software, one nonmaskable
// - Hardware requests from bus write or pin
// - Hardware pins sampled each rising clock
// - Nonmaskable pin sampled; bus write also raises
// - Write with bus bits 6:4 zero hits latch
// - Latch is write only, never read back
// - Bits 22:16 enable, bits 6:0 give values
// - Latch bit 5 or pin, timer muxed
// - Latch bits 4:0 or pins into pending
// - Nonmaskable is latch bit 6 or pin
// - Only assertion edge raises nonmaskable exception
// - Pending bits ANDed with mask, then ORed
// - Result gated by global enable
`timescale 1ns/100ps
`include "icm_consts.svh"
module interrupt_collect_mask
    import icm_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    reset_n,
    input  wire logic [`ICM_BUS_W-1:0]   sysAddrDataBus,
    input  wire logic                    extWriteAddr,
    input  wire logic                    extWriteData,
    input  wire logic [`ICM_HW_PINS-1:0] intPin_n,
    input  wire logic                    nmiPin_n,
    input  wire logic                    timerRequest,
    input  wire logic                    timerSelect,
    input  wire logic [1:0]              softwareRequest,
    input  wire logic [`ICM_PEND_W-1:0]  maskBits,
    input  wire logic                    globalIrqEnable,
    output logic      [`ICM_PEND_W-1:0]  pendingBits,
    output logic                         interruptRequest,
    output logic                         nmiException
);
    icm_state_t st_reg;
    icm_state_t st_next;

    logic [`ICM_LATCH_W-1:0] writeEnables;
    logic [`ICM_LATCH_W-1:0] writeValues;
    logic [`ICM_LATCH_W-1:0] latchWritten;
    logic [`ICM_HW_PINS-1:0] hwRequest;
    logic                    nmiLevel;
    logic                    selectHit;

    assign writeEnables = sysAddrDataBus[`ICM_WE_MSB:`ICM_WE_LSB];
    assign writeValues  = sysAddrDataBus[`ICM_VAL_MSB:`ICM_VAL_LSB];
    assign latchWritten = (st_reg.latchBits & ~writeEnables) | (writeValues & writeEnables);
    assign selectHit    = sysAddrDataBus[`ICM_SEL_MSB:`ICM_SEL_LSB] == `ICM_SEL_HIT;
    // Pins are active low; latch bits OR onto them
    assign hwRequest    = st_reg.latchBits[`ICM_TMR_BIT:0] | ~st_reg.intSync2;
    assign nmiLevel     = st_reg.latchBits[`ICM_NMI_BIT] | ~st_reg.nmiSync2;

    always_comb begin
        st_next = st_reg;
        // Two-stage sampling of the pins
        st_next.intSync1 = intPin_n;
        st_next.intSync2 = st_reg.intSync1;
        st_next.nmiSync1 = nmiPin_n;
        st_next.nmiSync2 = st_reg.nmiSync1;
        // Address cycle decides whether the data cycle lands in the latch
        if (extWriteAddr) begin
            st_next.addrHit = selectHit;
        end else if (extWriteData) begin
            st_next.addrHit = 1'b0;
        end
        // No read path exists for the latch
        if (extWriteData && st_reg.addrHit) begin
            st_next.latchBits = latchWritten;
        end
        st_next.nmiPrev      = nmiLevel;
        st_next.nmiException = nmiLevel & ~st_reg.nmiPrev;
        st_next.pendingBits[`ICM_PEND_TOP] = timerSelect ? timerRequest
                                                         : hwRequest[`ICM_TMR_BIT];
        st_next.pendingBits[`ICM_PEND_HW_MSB:`ICM_PEND_HW_LSB] = hwRequest[`ICM_HW_MSB:0];
        st_next.pendingBits[`ICM_PEND_SW_MSB:0] = softwareRequest;
        st_next.interruptRequest = (|(st_reg.pendingBits & maskBits)) & globalIrqEnable;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_reg <= '0;
            st_reg.intSync1 <= '1;
            st_reg.intSync2 <= '1;
            st_reg.nmiSync1 <= 1'b1;
            st_reg.nmiSync2 <= 1'b1;
            st_reg.nmiPrev  <= 1'b1;
            st_reg.latchBits <= `ICM_LATCH_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pendingBits      = st_reg.pendingBits;
    assign interruptRequest = st_reg.interruptRequest;
    assign nmiException     = st_reg.nmiException;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    logic [`ICM_LATCH_W-1:0] latchPrev;
    logic [`ICM_PEND_W-1:0]  maskedPend;
    assign latchPrev  = st_reg.latchBits;
    assign maskedPend = st_reg.pendingBits & maskBits;

    sequence s_hit_addr;
        extWriteAddr && selectHit;
    endsequence
    sequence s_miss_addr;
        extWriteAddr && !selectHit;
    endsequence
    sequence s_data_only;
        extWriteData && !extWriteAddr;
    endsequence

    sequence s_unpaired_data;
        extWriteData && !st_reg.addrHit;
    endsequence

    sequence s_nmi_set_data;
        extWriteData && !extWriteAddr && writeEnables[`ICM_NMI_BIT] && writeValues[`ICM_NMI_BIT];
    endsequence

    sequence s_pins_held;
        intPin_n != '1 ##1 $stable(intPin_n) ##1 $stable(intPin_n);
    endsequence

    // Latch write path and reset clearing
    a_latch_write: assert property (s_hit_addr ##1 s_data_only |=>
            st_reg.latchBits == (($past(latchPrev) & ~$past(writeEnables))
                                | ($past(writeValues) & $past(writeEnables))))
        else $error("latch write did not apply enabled bits");

    a_latch_miss: assert property (s_miss_addr ##1 s_data_only |=>
            st_reg.latchBits == $past(latchPrev))
        else $error("latch changed on unselected write");

    a_latch_idle: assert property (!extWriteData |=> st_reg.latchBits == $past(latchPrev))
        else $error("latch changed without a data cycle");

    a_unpaired_data: assert property (s_unpaired_data |=>
            st_reg.latchBits == $past(latchPrev))
        else $error("latch changed on data without selected address");

    a_addr_hit: assert property (s_hit_addr |=>
            st_reg.addrHit)
        else $error("selected address not recorded");

    a_addr_miss: assert property (s_miss_addr |=>
            !st_reg.addrHit)
        else $error("unselected address recorded as hit");

    a_hit_once: assert property (s_data_only |=>
            !st_reg.addrHit)
        else $error("address hit outlived its data cycle");

    a_latch_reset: assert property (@(posedge clock) $rose(reset_n) |-> st_reg.latchBits == `ICM_LATCH_RESET)
        else $error("latch not cleared by reset");

    a_reset_out: assert property ($rose(reset_n) |->
            pendingBits == '0 && !interruptRequest && !nmiException)
        else $error("outputs not cleared by reset");

    // Pending bits
    a_pin_sample: assert property (s_pins_held |=>
            (pendingBits[`ICM_PEND_HW_MSB:`ICM_PEND_HW_LSB] & ~$past(intPin_n[`ICM_HW_MSB:0], 3))
            == ~$past(intPin_n[`ICM_HW_MSB:0], 3))
        else $error("asserted pins not pending");

    a_pin_top: assert property (!timerSelect && !st_reg.intSync2[`ICM_TMR_BIT] |=>
            pendingBits[`ICM_PEND_TOP])
        else $error("pin five not pending");

    a_latch_top: assert property (!timerSelect && st_reg.latchBits[`ICM_TMR_BIT] |=>
            pendingBits[`ICM_PEND_TOP])
        else $error("latch bit five not pending");

    a_pend_top: assert property (timerSelect |=> pendingBits[`ICM_PEND_TOP] == $past(timerRequest))
        else $error("timer select not honoured");

    a_latch_pend: assert property (##1
            (pendingBits[`ICM_PEND_HW_MSB:`ICM_PEND_HW_LSB] & $past(latchPrev[`ICM_HW_MSB:0]))
            == $past(latchPrev[`ICM_HW_MSB:0]))
        else $error("latch bits not pending");

    a_sw_pend: assert property (##1
            pendingBits[`ICM_PEND_SW_MSB:0] == $past(softwareRequest))
        else $error("software requests not pending");

    // Masking
    a_irq_mask: assert property (##1 interruptRequest == ((|$past(maskedPend)) && $past(globalIrqEnable)))
        else $error("interrupt request mismatch");

    a_irq_gate: assert property (!globalIrqEnable |=>
            !interruptRequest)
        else $error("request raised while globally disabled");

    // Nonmaskable request
    a_nmi_pin: assert property (!nmiPin_n |-> ##2
            nmiLevel)
        else $error("nonmaskable pin not sampled");

    a_nmi_write: assert property (s_hit_addr ##1 s_nmi_set_data |=>
            nmiLevel)
        else $error("nonmaskable latch bit not set");

    a_nmi_edge: assert property (!nmiLevel ##1 nmiLevel |=> nmiException)
        else $error("nonmaskable edge missed");

    a_nmi_level: assert property (nmiLevel ##1 nmiLevel |=> !nmiException)
        else $error("nonmaskable raised by steady level");

    a_nmi_pulse: assert property (nmiException |=>
            !nmiException)
        else $error("nonmaskable exception longer than one cycle");

    a_nmi_cause: assert property (nmiException |->
            $past(nmiLevel) && !$past(nmiLevel, 2))
        else $error("nonmaskable exception without an edge");
endmodule // interrupt_collect_mask

// >>> verification/icm_agent.sv
// External agent model: latch writes and interrupt pins
`timescale 1ns/100ps
`include "icm_consts.svh"
module icm_agent (
    input  wire logic                    clock,
    output logic      [`ICM_BUS_W-1:0]   sysAddrDataBus,
    output logic                         extWriteAddr,
    output logic                         extWriteData,
    output logic      [`ICM_HW_PINS-1:0] intPin_n,
    output logic                         nmiPin_n
);
    initial begin
        sysAddrDataBus = 64'h0;
        extWriteAddr = 1'b0;
        extWriteData = 1'b0;
        intPin_n = 6'h3F;
        nmiPin_n = 1'b1;
    end
    task automatic wr(input logic [2:0] sel, input logic [6:0] en, input logic [6:0] val);
        @(negedge clock);
        extWriteAddr = 1'b1;
        sysAddrDataBus = {57'h0, sel, 4'h0};
        @(negedge clock);
        extWriteAddr = 1'b0;
        extWriteData = 1'b1;
        sysAddrDataBus = {41'h0, en, 9'h0, val};
        @(negedge clock);
        extWriteData = 1'b0;
        sysAddrDataBus = ~sysAddrDataBus;
    endtask
    task automatic pins(input logic [5:0] hw, input logic nmi);
        @(negedge clock);
        intPin_n = hw;
        nmiPin_n = nmi;
    endtask
endmodule // icm_agent

// >>> verification/interrupt_collect_mask_bench.sv
// Self-checking bench for the interrupt collect and mask block
`timescale 1ns/100ps
`include "icm_consts.svh"
module interrupt_collect_mask_bench;
    logic clock, reset_n, extWriteAddr, extWriteData, nmiPin_n, timerRequest, timerSelect, globalIrqEnable;
    logic [63:0] sysAddrDataBus;
    logic [5:0]  intPin_n;
    logic [1:0]  softwareRequest;
    logic [7:0]  maskBits, pendingBits;
    logic        interruptRequest, nmiException;
    int          failCount = 0, nCompared = 0, nmiCount = 0;
    icm_agent agent (.clock(clock), .sysAddrDataBus(sysAddrDataBus), .extWriteAddr(extWriteAddr),
        .extWriteData(extWriteData), .intPin_n(intPin_n), .nmiPin_n(nmiPin_n));
    interrupt_collect_mask dut (.clock(clock), .reset_n(reset_n), .sysAddrDataBus(sysAddrDataBus),
        .extWriteAddr(extWriteAddr), .extWriteData(extWriteData), .intPin_n(intPin_n), .nmiPin_n(nmiPin_n),
        .timerRequest(timerRequest), .timerSelect(timerSelect), .softwareRequest(softwareRequest),
        .maskBits(maskBits), .globalIrqEnable(globalIrqEnable), .pendingBits(pendingBits),
        .interruptRequest(interruptRequest), .nmiException(nmiException));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(negedge clock) if (nmiException === 1'b1) nmiCount++;
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic endSim();
        $display("Compared %0d, mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        failCount++;
        endSim();
    end
    initial begin
        reset_n = 1'b0;
        {timerRequest, timerSelect, globalIrqEnable} = 3'h0;
        softwareRequest = 2'h0;
        maskBits = 8'h00;
        wt(12);
        reset_n = 1'b1;
        wt(1);
        chk("pend", 8'h00, pendingBits);
        agent.wr(3'h0, 7'h7F, 7'h1F);
        wt(3);
        chk("pend", 8'h7C, pendingBits);
        agent.wr(3'h5, 7'h7F, 7'h00);
        wt(3);
        chk("pend", 8'h7C, pendingBits);
        agent.wr(3'h0, 7'h20, 7'h20);
        wt(3);
        chk("pend", 8'hFC, pendingBits);
        timerSelect = 1'b1;
        wt(2);
        chk("pend", 8'h7C, pendingBits);
        timerRequest = 1'b1;
        agent.wr(3'h0, 7'h7F, 7'h00);
        wt(3);
        chk("pend", 8'h80, pendingBits);
        {timerRequest, timerSelect} = 2'h0;
        agent.pins(6'h3E, 1'b1);
        wt(4);
        chk("pend", 8'h04, pendingBits);
        maskBits = 8'h04;
        globalIrqEnable = 1'b1;
        wt(2);
        chk("irq", 8'h01, {7'h0, interruptRequest});
        maskBits = 8'hFB;
        wt(2);
        chk("irq", 8'h00, {7'h0, interruptRequest});
        agent.pins(6'h1F, 1'b1);
        softwareRequest = 2'h3;
        wt(4);
        chk("pend", 8'h83, pendingBits);
        globalIrqEnable = 1'b0;
        wt(2);
        chk("irq", 8'h00, {7'h0, interruptRequest});
        agent.pins(6'h3F, 1'b0);
        wt(10);
        chk("nmi", 8'h01, nmiCount[7:0]);
        wt(10);
        chk("nmi", 8'h01, nmiCount[7:0]);
        agent.pins(6'h3F, 1'b1);
        wt(4);
        agent.wr(3'h0, 7'h40, 7'h40);
        wt(4);
        chk("nmi", 8'h02, nmiCount[7:0]);
        softwareRequest = 2'h0;
        maskBits = 8'hFF;
        globalIrqEnable = 1'b1;
        agent.wr(3'h0, 7'h1F, 7'h1F);
        wt(3);
        chk("pend", 8'h7C, pendingBits);
        chk("irq", 8'h01, {7'h0, interruptRequest});
        reset_n = 1'b0;
        wt(2);
        reset_n = 1'b1;
        wt(2);
        chk("pend", 8'h00, pendingBits);
        chk("irq", 8'h00, {7'h0, interruptRequest});
        chk("nmi", 8'h02, nmiCount[7:0]);
        endSim();
    end
endmodule // interrupt_collect_mask_bench
